// ---- flash_bus_cycle.sv ----
/*
  One asynchronous flash bus cycle, read or write, with every pin from a flip-flop.
  Assumes the flash answers within the strobe time and that inputs are synchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none

module flash_bus_cycle (
  input  wire logic                              clk_i,
  input  wire logic                              rst_n_i,
  input  wire logic                              start_i,
  input  wire logic                              write_i,
  input  wire logic [flash_host_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [flash_host_pkg::DATA_W-1:0] wdata_i,
  output var  logic                              done_o,
  output var  logic [flash_host_pkg::DATA_W-1:0] rdata_o,
  output var  logic [flash_host_pkg::ADDR_W-1:0] addr_o,
  output var  logic                              ce_n_o,
  output var  logic                              we_n_o,
  output var  logic                              oe_n_o,
  input  wire logic [flash_host_pkg::DATA_W-1:0] dq_i,
  output var  logic [flash_host_pkg::DATA_W-1:0] dq_o,
  output var  logic                              dq_oen_o
);

  typedef enum logic [3:0] {
    P_IDLE   = 4'h1,
    P_SETUP  = 4'h2,
    P_STROBE = 4'h4,
    P_HOLD   = 4'h8
  } phase_e;

  phase_e                            phase_q;
  logic   [flash_host_pkg::CNT_W-1:0] cnt_q;
  logic                              wr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Phase decode as named wires.
  wire cnt_zero   = (cnt_q == '0);
  wire setup_end  = (phase_q == P_SETUP) && cnt_zero;
  wire strobe_end = (phase_q == P_STROBE) && cnt_zero;

  // Sequencer: select falls first, the strobe later, so the flash takes the address on
  // the strobe edge; the strobe rises before select so data is taken on it. Strobes last
  // whole clock periods, far above any glitch filter.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_q  <= P_IDLE;
      cnt_q    <= '0;
      wr_q     <= 1'b0;
      done_o   <= 1'b0;
      rdata_o  <= '0;
      addr_o   <= '0;
      ce_n_o   <= 1'b1;
      we_n_o   <= 1'b1;
      oe_n_o   <= 1'b1;
      dq_o     <= '0;
      dq_oen_o <= 1'b1;
    end else begin
      done_o <= 1'b0;
      case (phase_q)
        P_IDLE: begin
          if (start_i) begin
            phase_q  <= P_SETUP;
            cnt_q    <= flash_host_pkg::CNT_W'(flash_host_pkg::SETUP_CYC - 1);
            wr_q     <= write_i;
            addr_o   <= addr_i;
            dq_o     <= wdata_i;
            dq_oen_o <= !write_i;
            ce_n_o   <= 1'b0;
          end
        end
        P_SETUP: begin
          cnt_q <= cnt_q - 1'b1;
          if (setup_end) begin
            phase_q <= P_STROBE;
            cnt_q   <= flash_host_pkg::CNT_W'(flash_host_pkg::STROBE_CYC - 1);
            we_n_o  <= !wr_q;
            oe_n_o  <= wr_q;
          end
        end
        P_STROBE: begin
          cnt_q <= cnt_q - 1'b1;
          if (strobe_end) begin
            phase_q <= P_HOLD;
            we_n_o  <= 1'b1;
            oe_n_o  <= 1'b1;
            if (!wr_q) begin
              rdata_o <= dq_i;
            end
          end
        end
        P_HOLD: begin
          phase_q  <= P_IDLE;
          ce_n_o   <= 1'b1;    // Data stays driven until this edge.
          dq_oen_o <= 1'b1;
          done_o   <= 1'b1;
        end
        default: begin
          phase_q <= P_IDLE;
        end
      endcase
    end
  end

endmodule : flash_bus_cycle

`default_nettype wire

// ---- flash_dev_model.sv ----
/* Behavioural parallel NOR flash: command register, identification, status flag.
   Assumes the host drives the strobes; tmo_i raises the timeout flag, busy_i marks an embedded operation. */
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model #(
  parameter logic [7:0]  MAKER = 8'h4d,  // Arbitrary value.
  parameter logic [15:0] PART  = 16'h62e1, // Arbitrary value.
  parameter logic [7:0]  CONT  = 8'h6b,  // Arbitrary value.
  parameter logic [6:0]  PROT  = 7'h05
) (
  input  wire logic        ce_n_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  input  wire logic [18:0] addr_i,
  input  wire logic [15:0] dq_i,
  input  wire logic        vid_i,
  input  wire logic        byte_n_i,
  input  wire logic        tmo_i,
  input  wire logic        busy_i,
  output logic      [15:0] dq_o
);
  logic [18:0] a_q;
  logic [15:0] last_q = 16'h0;
  logic [1:0]  st_q = 2'h0; // Starts in array read.
  logic        tmo_q = 1'b0;
  logic        armed_q = 1'b0;
  realtime     t_q;
  wire         wr = !ce_n_i && !we_n_i && oe_n_i;
  wire [18:0]  exp_a = (st_q == 2'h1) ? flash_host_pkg::UNLOCK2_ADDR : flash_host_pkg::UNLOCK1_ADDR;
  wire [7:0]   exp_d = (st_q == 2'h0) ? 8'haa : (st_q == 2'h1) ? 8'h55 : 8'h90;
  ////////////////////////////////////////////////////////////////////////////
  // Address on the later falling edge; only a full edge arms a write.
  always @(posedge wr) begin
    a_q = addr_i;
    t_q = $realtime;
    armed_q = 1'b1;
  end
  always @(posedge tmo_i) tmo_q = 1'b1;
  // Data on the first rising edge; short pulses are dropped.
  always @(negedge wr) begin
    // A running embedded operation ignores every command, reset included.
    if (armed_q && !busy_i && ($realtime - t_q) >= 5.0) begin
      if (dq_i[7:0] == 8'hf0) begin
        st_q = 2'h0;
        tmo_q = 1'b0;
      end else if (st_q != 2'h3) begin
        st_q = (a_q == exp_a && dq_i[7:0] == exp_d) ? st_q + 2'h1 : 2'h0;
      end
    end
    armed_q = 1'b0;
  end
  // Read value; a released bus shows the inverse of the last value.
  wire [15:0] code = (addr_i[1:0] == 2'h0) ? {8'h00, MAKER} : (addr_i[1:0] == 2'h1) ? PART :
                     (addr_i[1:0] == 2'h3) ? {8'h00, CONT} : {15'h0, addr_i[18:12] == PROT};
  wire [15:0] val = ((vid_i && !addr_i[6]) || st_q == 2'h3) ? code :
                    tmo_q ? 16'h0020 : (addr_i[15:0] ^ 16'ha5c3);
  always @(posedge oe_n_i) last_q = val;
  assign dq_o = (!ce_n_i && !oe_n_i) ? (byte_n_i ? val : {~last_q[15:8], val[7:0]}) : ~last_q;
endmodule : flash_dev_model
`default_nettype wire

// ---- flash_host.sv ----
/*
  Host controller for a parallel NOR flash: array reads and writes, reset command,
  in-system identification by command and by the high-voltage address pin.
  Assumes an external switch puts the identification voltage on address bit nine while
  FLASH_VID_EN_O is high, and that user commands are synchronous to CLOCK_I.
*/
`timescale 1ns/100ps
`default_nettype none

module flash_host #(
  parameter logic [flash_host_pkg::ADDR_W-1:0] P_UNLOCK1_ADDR = flash_host_pkg::UNLOCK1_ADDR,
  parameter logic [flash_host_pkg::ADDR_W-1:0] P_UNLOCK2_ADDR = flash_host_pkg::UNLOCK2_ADDR,
  parameter logic [7:0]                        P_UNLOCK1_DATA = flash_host_pkg::UNLOCK1_DATA,
  parameter logic [7:0]                        P_UNLOCK2_DATA = flash_host_pkg::UNLOCK2_DATA,
  parameter logic [7:0]                        P_ID_CMD       = flash_host_pkg::ID_CMD,
  parameter logic [7:0]                        P_RESET_CMD    = flash_host_pkg::RESET_CMD
) (
  input  wire logic                              CLOCK_I,
  input  wire logic                              RESETN_I,
  input  wire logic                              CMD_VALID_I,
  input  wire logic [2:0]                        CMD_OP_I,
  input  wire logic [flash_host_pkg::ADDR_W-1:0] CMD_ADDR_I,
  input  wire logic [flash_host_pkg::DATA_W-1:0] CMD_DATA_I,
  input  wire logic                              BYTE_MODE_I,
  output var  logic                              CMD_READY_O,
  output var  logic                              RD_VALID_O,
  output var  logic [flash_host_pkg::DATA_W-1:0] RD_DATA_O,
  output var  logic                              ID_MODE_O,
  output var  logic                              TIMEOUT_SEEN_O,
  output var  logic                              FLASH_VID_EN_O,
  output var  logic                              FLASH_BYTE_N_O,
  output logic      [flash_host_pkg::ADDR_W-1:0] FLASH_ADDR_O,
  output logic                                   FLASH_CE_N_O,
  output logic                                   FLASH_WE_N_O,
  output logic                                   FLASH_OE_N_O,
  input  wire logic [flash_host_pkg::DATA_W-1:0] FLASH_DQ_I,
  output logic      [flash_host_pkg::DATA_W-1:0] FLASH_DQ_O,
  output logic                                   FLASH_DQ_OEN_O
);

  typedef enum logic [5:0] {
    S_PWRUP  = 6'h01,
    S_IDLE   = 6'h02,
    S_SETTLE = 6'h04,
    S_ISSUE  = 6'h08,
    S_WAIT   = 6'h10,
    S_FINISH = 6'h20
  } state_e;

  state_e                                state_q;
  logic   [flash_host_pkg::CNT_W-1:0]    cnt_q;
  logic   [2:0]                          op_q;
  logic   [flash_host_pkg::ADDR_W-1:0]   addr_q;
  logic   [flash_host_pkg::DATA_W-1:0]   data_q;
  logic                                  pre_q;
  logic   [1:0]                          step_q;
  logic                                  start_q;
  logic                                  cyc_done;
  logic   [flash_host_pkg::DATA_W-1:0]   cyc_rdata;
  flash_host_pkg::kind_e                 kind;
  logic   [flash_host_pkg::ADDR_W-1:0]   cyc_addr;
  logic   [flash_host_pkg::DATA_W-1:0]   cyc_wdata;
  logic   [1:0]                          last_step;

  ////////////////////////////////////////////////////////////////////////////
  // Operation decode.
  wire is_read   = (op_q == flash_host_pkg::OP_READ);
  wire is_idrd   = (op_q == flash_host_pkg::OP_ID_READ) || (op_q == flash_host_pkg::OP_PROT_READ);
  wire is_enter  = (op_q == flash_host_pkg::OP_ID_ENTER);
  wire is_hv     = (op_q == flash_host_pkg::OP_HV_READ);
  wire is_poll   = (op_q == flash_host_pkg::OP_POLL);
  wire returns   = is_read || is_idrd || is_hv || is_poll;
  wire cmd_take  = (state_q == S_IDLE) && CMD_VALID_I;
  wire new_hv    = (CMD_OP_I == flash_host_pkg::OP_HV_READ);
  wire [1:0] sel = addr_q[1:0];

  // An array read must be preceded by a reset write once the device may sit in
  // identification mode or has reported a timeout; an identification read needs the
  // entry sequence first unless the device is known to be in that mode already.
  wire new_pre = (CMD_OP_I == flash_host_pkg::OP_READ) ? (ID_MODE_O || TIMEOUT_SEEN_O) :
                 ((CMD_OP_I == flash_host_pkg::OP_ID_READ) ||
                  (CMD_OP_I == flash_host_pkg::OP_PROT_READ)) ? !ID_MODE_O : 1'b0;

  // Length of the sequence, minus one.
  assign last_step = is_enter ? 2'h2 :
                     (is_idrd && pre_q) ? 2'h3 :
                     (is_read && pre_q) ? 2'h1 : 2'h0;

  // Kind of the current bus cycle.
  assign kind = (op_q == flash_host_pkg::OP_WRITE) ? flash_host_pkg::K_WRITE :
                (op_q == flash_host_pkg::OP_RESET) ? flash_host_pkg::K_RESET :
                (is_read && pre_q && step_q == 2'h0) ? flash_host_pkg::K_RESET :
                ((is_enter || (is_idrd && pre_q)) && step_q == 2'h0) ? flash_host_pkg::K_UNLOCK1 :
                ((is_enter || (is_idrd && pre_q)) && step_q == 2'h1) ? flash_host_pkg::K_UNLOCK2 :
                ((is_enter || (is_idrd && pre_q)) && step_q == 2'h2) ? flash_host_pkg::K_IDCMD :
                flash_host_pkg::K_READ;

  // Address of the current cycle. The reset command may go to any address, so the
  // user address is reused. High-voltage reads hold A6 low and put the code select on
  // A1/A0 with the sector on the top bits; protection reads put 02h under the sector.
  wire [flash_host_pkg::ADDR_W-1:0] hv_addr = {addr_q[flash_host_pkg::ADDR_W-1:flash_host_pkg::SECT_LSB],
                                               5'h00, 1'b0, 4'h0, sel};
  wire [flash_host_pkg::ADDR_W-1:0] prot_addr = {addr_q[flash_host_pkg::ADDR_W-1:flash_host_pkg::SECT_LSB],
                                                 10'h000, flash_host_pkg::SEL_PROTECT};
  wire [flash_host_pkg::ADDR_W-1:0] id_addr = {addr_q[flash_host_pkg::ADDR_W-1:8], 6'h00, sel};
  wire [flash_host_pkg::ADDR_W-1:0] rd_addr =
    is_hv ? hv_addr :
    (op_q == flash_host_pkg::OP_PROT_READ) ? prot_addr :
    (op_q == flash_host_pkg::OP_ID_READ) ? id_addr : addr_q;

  assign cyc_addr = (kind == flash_host_pkg::K_UNLOCK1) ? P_UNLOCK1_ADDR :
                    (kind == flash_host_pkg::K_UNLOCK2) ? P_UNLOCK2_ADDR :
                    (kind == flash_host_pkg::K_IDCMD)   ? P_UNLOCK1_ADDR :
                    (kind == flash_host_pkg::K_READ)    ? rd_addr : addr_q;

  assign cyc_wdata = (kind == flash_host_pkg::K_UNLOCK1) ? {8'h00, P_UNLOCK1_DATA} :
                     (kind == flash_host_pkg::K_UNLOCK2) ? {8'h00, P_UNLOCK2_DATA} :
                     (kind == flash_host_pkg::K_IDCMD)   ? {8'h00, P_ID_CMD} :
                     (kind == flash_host_pkg::K_RESET)   ? {8'h00, P_RESET_CMD} : data_q;

  // In byte mode only the low data lines carry the answer.
  wire [flash_host_pkg::DATA_W-1:0] rd_masked = BYTE_MODE_I ? {8'h00, cyc_rdata[7:0]} : cyc_rdata;
  wire step_last = (step_q == last_step);

  ////////////////////////////////////////////////////////////////////////////
  // One bus cycle engine drives the address, strobe and data pins from its own flip-flops.
  flash_bus_cycle u_cycle (
    .clk_i    (CLOCK_I),
    .rst_n_i  (RESETN_I),
    .start_i  (start_q),
    .write_i  (kind != flash_host_pkg::K_READ),
    .addr_i   (cyc_addr),
    .wdata_i  (cyc_wdata),
    .done_o   (cyc_done),
    .rdata_o  (cyc_rdata),
    .addr_o   (FLASH_ADDR_O),
    .ce_n_o   (FLASH_CE_N_O),
    .we_n_o   (FLASH_WE_N_O),
    .oe_n_o   (FLASH_OE_N_O),
    .dq_i     (FLASH_DQ_I),
    .dq_o     (FLASH_DQ_O),
    .dq_oen_o (FLASH_DQ_OEN_O)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer. After reset the strobes stay high for a quiet period, so a flash still
  // powering up never sees a write edge; plain reads then need no command at all.
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_q <= S_PWRUP;
      cnt_q   <= flash_host_pkg::CNT_W'(flash_host_pkg::PWRUP_CYC - 1);
      op_q    <= 3'h0;
      addr_q  <= '0;
      data_q  <= '0;
      pre_q   <= 1'b0;
      step_q  <= 2'h0;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      case (state_q)
        S_PWRUP: begin
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q == '0) begin
            state_q <= S_IDLE;
          end
        end
        S_IDLE: begin
          if (cmd_take) begin
            op_q    <= CMD_OP_I;
            addr_q  <= CMD_ADDR_I;
            data_q  <= CMD_DATA_I;
            pre_q   <= new_pre;
            step_q  <= 2'h0;
            cnt_q   <= flash_host_pkg::CNT_W'(flash_host_pkg::VID_CYC - 1);
            state_q <= new_hv ? S_SETTLE : S_ISSUE;
          end
        end
        S_SETTLE: begin
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q == '0) begin
            state_q <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          start_q <= 1'b1;
          state_q <= S_WAIT;
        end
        S_WAIT: begin
          if (cyc_done) begin
            step_q  <= step_q + 2'h1;
            state_q <= step_last ? S_FINISH : S_ISSUE;
          end
        end
        S_FINISH: begin
          state_q <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host view of the device mode. A reset write is the only way out of identification
  // mode; a reported timeout clears on a reset write or on a poll that reads the flag low;
  // the entry command is the only way in.
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ID_MODE_O      <= 1'b0;
      TIMEOUT_SEEN_O <= 1'b0;
    end else if ((state_q == S_WAIT) && cyc_done) begin
      if (kind == flash_host_pkg::K_RESET) begin
        ID_MODE_O      <= 1'b0;
        TIMEOUT_SEEN_O <= 1'b0;
      end else if (kind == flash_host_pkg::K_IDCMD) begin
        ID_MODE_O <= 1'b1;
      end else if (is_poll && (kind == flash_host_pkg::K_READ)) begin
        TIMEOUT_SEEN_O <= cyc_rdata[flash_host_pkg::TIMEOUT_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // User-facing outputs and the identification voltage enable.
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      CMD_READY_O    <= 1'b0;
      RD_VALID_O     <= 1'b0;
      RD_DATA_O      <= '0;
      FLASH_VID_EN_O <= 1'b0;
      FLASH_BYTE_N_O <= 1'b1;
    end else begin
      FLASH_BYTE_N_O <= !BYTE_MODE_I;
      RD_VALID_O     <= (state_q == S_FINISH) && returns;
      CMD_READY_O    <= (state_q == S_IDLE) ? !cmd_take : (state_q == S_FINISH);
      if ((state_q == S_WAIT) && cyc_done && (kind == flash_host_pkg::K_READ)) begin
        RD_DATA_O <= rd_masked;
      end
      if (cmd_take && new_hv) begin
        FLASH_VID_EN_O <= 1'b1;
      end else if (state_q == S_FINISH) begin
        FLASH_VID_EN_O <= 1'b0;
      end
    end
  end

endmodule : flash_host

`default_nettype wire

// ---- flash_host_pkg.sv ----
/*
  Constants, codes and encodings shared by the parallel NOR flash host controller.
  Assumes a 10 MHz controller clock and a flash with a 19-bit word address and 16-bit data.
*/
// What this block does
// - High-voltage ID: bit nine raised, bits 6/1/0 select code.
// - Protection verify: sector on top address bits.
// - Write only with select, strobe low, output-enable high.
// - Host resets before array read after timeout/ID.
// - Two unlocks plus ID command enter identification.
`default_nettype none

package flash_host_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths of the flash pins.
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Timing, each figure in its own unit, then as clock cycles at CLK_MHZ.
  localparam int CLK_MHZ      = 10;
  localparam int T_SETUP_NS   = 50;   // Address and select ahead of the strobe.
  localparam int T_STROBE_NS  = 90;   // Strobe low time, covers read access.
  localparam int T_VID_NS     = 500;  // Settling of the identification voltage.
  localparam int T_PWRUP_US   = 50;   // Quiet time after reset before any cycle.
  localparam int SETUP_CYC    = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_CYC   = (T_STROBE_NS * CLK_MHZ + 999) / 1000 + 1;
  localparam int VID_CYC      = (T_VID_NS * CLK_MHZ + 999) / 1000;
  localparam int PWRUP_CYC    = T_PWRUP_US * CLK_MHZ;
  localparam int CNT_W        = 10;

  ////////////////////////////////////////////////////////////////////////////
  // Command sequence codes; defaults for the top module parameters.
  localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 19'h00555;
  localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 19'h002aa;
  localparam logic [7:0]        UNLOCK1_DATA = 8'haa;
  localparam logic [7:0]        UNLOCK2_DATA = 8'h55;
  localparam logic [7:0]        ID_CMD       = 8'h90;
  localparam logic [7:0]        RESET_CMD    = 8'hf0;

  ////////////////////////////////////////////////////////////////////////////
  // Address fields used during identification reads, and the data bit of the timeout flag.
  localparam int              SECT_LSB    = 12;
  localparam logic [1:0]      SEL_MAKER   = 2'h0;
  localparam logic [1:0]      SEL_PART    = 2'h1;
  localparam logic [1:0]      SEL_PROTECT = 2'h2;
  localparam logic [1:0]      SEL_CONT    = 2'h3;
  localparam int              TIMEOUT_BIT = 5;

  ////////////////////////////////////////////////////////////////////////////
  // User operations.
  typedef enum logic [2:0] {
    OP_READ      = 3'h0,
    OP_WRITE     = 3'h1,
    OP_RESET     = 3'h2,
    OP_ID_ENTER  = 3'h3,
    OP_ID_READ   = 3'h4,
    OP_PROT_READ = 3'h5,
    OP_HV_READ   = 3'h6,
    OP_POLL      = 3'h7
  } op_e;

  // Kind of a single bus cycle inside a sequence.
  typedef enum logic [2:0] {
    K_READ    = 3'h0,
    K_WRITE   = 3'h1,
    K_RESET   = 3'h2,
    K_UNLOCK1 = 3'h3,
    K_UNLOCK2 = 3'h4,
    K_IDCMD   = 3'h5
  } kind_e;

endpackage : flash_host_pkg

`default_nettype wire

// ---- flash_host_properties.sv ----
/* Pin-timing checker for the flash host controller.
   Bound to flash_host and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module flash_host_properties (
  input wire logic        CLOCK_I,
  input wire logic        RESETN_I,
  input wire logic        CMD_READY_O,
  input wire logic        RD_VALID_O,
  input wire logic        FLASH_VID_EN_O,
  input wire logic [18:0] FLASH_ADDR_O,
  input wire logic        FLASH_CE_N_O,
  input wire logic        FLASH_WE_N_O,
  input wire logic        FLASH_OE_N_O,
  input wire logic        FLASH_DQ_OEN_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);
  ////////////////////////////////////////////////////////////////////////////
  // Strobe qualification; a read and a write must never overlap on the pins.
  property p_we_qual; !FLASH_WE_N_O |-> !FLASH_CE_N_O && FLASH_OE_N_O && !FLASH_DQ_OEN_O; endproperty
  a_we_qual: assert property (p_we_qual) else $error("write strobe not qualified");
  property p_oe_qual; !FLASH_OE_N_O |-> !FLASH_CE_N_O && FLASH_WE_N_O && FLASH_DQ_OEN_O; endproperty
  a_oe_qual: assert property (p_oe_qual) else $error("read strobe not qualified");
  // Write pulses are two full cycles, far above any glitch filter.
  property p_we_width; $fell(FLASH_WE_N_O) |=> !FLASH_WE_N_O ##1 FLASH_WE_N_O; endproperty
  a_we_width: assert property (p_we_width) else $error("write pulse width wrong");
  property p_ce_lead; $fell(FLASH_WE_N_O) |-> !$past(FLASH_CE_N_O); endproperty
  a_ce_lead: assert property (p_ce_lead) else $error("select not ahead of strobe");
  property p_addr_hold; $fell(FLASH_WE_N_O) |-> $stable(FLASH_ADDR_O) [*3]; endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved in write");
  property p_ce_trail; $rose(FLASH_WE_N_O) |-> !FLASH_CE_N_O ##1 FLASH_CE_N_O; endproperty
  a_ce_trail: assert property (p_ce_trail) else $error("select release wrong");
  // No write may ever happen with the identification voltage applied.
  property p_vid_nowr; FLASH_VID_EN_O |-> FLASH_WE_N_O; endproperty
  a_vid_nowr: assert property (p_vid_nowr) else $error("write under high voltage");
  property p_vid_a6; FLASH_VID_EN_O && !FLASH_OE_N_O |-> !FLASH_ADDR_O[6]; endproperty
  a_vid_a6: assert property (p_vid_a6) else $error("bit six high in code read");
  property p_rd_pulse; RD_VALID_O |-> CMD_READY_O ##1 !RD_VALID_O; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read valid not a pulse");
endmodule : flash_host_properties
bind flash_host flash_host_properties u_props (.CLOCK_I(CLOCK_I), .RESETN_I(RESETN_I),
  .CMD_READY_O(CMD_READY_O), .RD_VALID_O(RD_VALID_O), .FLASH_VID_EN_O(FLASH_VID_EN_O),
  .FLASH_ADDR_O(FLASH_ADDR_O), .FLASH_CE_N_O(FLASH_CE_N_O), .FLASH_WE_N_O(FLASH_WE_N_O),
  .FLASH_OE_N_O(FLASH_OE_N_O), .FLASH_DQ_OEN_O(FLASH_DQ_OEN_O));
`default_nettype wire

// ---- tb_top.sv ----
/* Self-checking bench for flash_host with a behavioural flash on its pins.
   Assumes the flash model and the bound pin checker. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [7:0]  MAKER = 8'h4d; // Arbitrary value.
  localparam logic [15:0] PART  = 16'h62e1; // Arbitrary value.
  localparam logic [7:0]  CONT  = 8'h6b; // Arbitrary value.
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        valid = 1'b0;
  logic        byte_mode = 1'b0;
  logic        tmo = 1'b0;
  logic        busy = 1'b0;
  logic [2:0]  op = 3'h0;
  logic [18:0] addr = 19'h0;
  logic [15:0] wdata = 16'h0;
  wire  [15:0] dq_bus, host_dq, dev_dq, rd_data;
  wire  [18:0] f_addr;
  wire         ready, rd_valid, id_mode, tmo_seen, vid, byte_n, ce_n, we_n, oe_n, dq_oen;
  int          n_mismatch = 0;
  int          checks_done = 0;
  always #50 clk = ~clk;
  assign dq_bus = dq_oen ? dev_dq : host_dq; // Whoever enables drives the shared lines.
  flash_host DUT (.CLOCK_I(clk), .RESETN_I(rst_n), .CMD_VALID_I(valid), .CMD_OP_I(op),
    .CMD_ADDR_I(addr), .CMD_DATA_I(wdata), .BYTE_MODE_I(byte_mode), .CMD_READY_O(ready),
    .RD_VALID_O(rd_valid), .RD_DATA_O(rd_data), .ID_MODE_O(id_mode), .TIMEOUT_SEEN_O(tmo_seen),
    .FLASH_VID_EN_O(vid), .FLASH_BYTE_N_O(byte_n), .FLASH_ADDR_O(f_addr), .FLASH_CE_N_O(ce_n),
    .FLASH_WE_N_O(we_n), .FLASH_OE_N_O(oe_n), .FLASH_DQ_I(dq_bus), .FLASH_DQ_O(host_dq),
    .FLASH_DQ_OEN_O(dq_oen));
  flash_dev_model #(.MAKER(MAKER), .PART(PART), .CONT(CONT), .PROT(7'h05)) u_dev (.ce_n_i(ce_n),
    .we_n_i(we_n), .oe_n_i(oe_n), .addr_i(f_addr), .dq_i(dq_bus), .vid_i(vid), .byte_n_i(byte_n),
    .tmo_i(tmo), .busy_i(busy), .dq_o(dev_dq));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  // One request, raised once ready is seen and held for one clock; then wait for its answer or idle.
  task automatic do_op(input logic [2:0] o, input logic [18:0] a, input logic [15:0] w,
                       output logic [15:0] d);
    int n;
    for (n = 0; n < 1000 && ready !== 1'b1; n++) @(negedge clk);
    check({15'h0, ready}, 16'h0001);
    op = o;
    addr = a;
    wdata = w;
    valid = 1'b1;
    @(negedge clk);
    valid = 1'b0;
    for (n = 0; n < 300 && rd_valid !== 1'b1 && ready !== 1'b1; n++) @(negedge clk);
    check({15'h0, ready}, 16'h0001);
    d = rd_data;
  endtask : do_op
  function automatic logic [15:0] arr(input logic [18:0] a);
    return a[15:0] ^ 16'ha5c3;
  endfunction : arr
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_array; // Array read without command, then a broken unlock.
    logic [15:0] d;
    do_op(3'h0, 19'h01234, 16'h0, d);
    check(d, arr(19'h01234));
    do_op(3'h1, 19'h00555, 16'h00aa, d);
    do_op(3'h1, 19'h002aa, 16'h0077, d);
    do_op(3'h0, 19'h04321, 16'h0, d);
    check(d, arr(19'h04321));
  endtask : t_array
  task automatic t_codes(input logic [2:0] o, input logic [6:0] s, input logic [15:0] p);
    logic [15:0] d;
    logic [15:0] codes [4];
    codes = '{{8'h00, MAKER}, PART, p, {8'h00, CONT}};
    for (int i = 0; i < 4; i++) begin
      do_op(o, {s, 10'h0, i[1:0]}, 16'h0, d);
      check(d, codes[i]);
    end
  endtask : t_codes
  task automatic t_id; // Command method, protection, exit by reset.
    logic [15:0] d;
    do_op(3'h3, 19'h0, 16'h0, d);
    check({15'h0, id_mode}, 16'h0001);
    t_codes(3'h4, 7'h05, 16'h0001);
    do_op(3'h5, 19'h06002, 16'h0, d);
    check(d, 16'h0000);
    do_op(3'h0, 19'h00abc, 16'h0, d);
    check(d, arr(19'h00abc));
    check({15'h0, id_mode}, 16'h0000);
    t_codes(3'h6, 7'h06, 16'h0000);
  endtask : t_id
  task automatic t_tmo; // Busy flash ignores entry; timeout flag seen by poll, cleared by reset.
    logic [15:0] d;
    busy = 1'b1;
    do_op(3'h3, 19'h0, 16'h0, d);
    busy = 1'b0;
    do_op(3'h4, 19'h00001, 16'h0, d);
    check(d, arr(19'h00001));
    tmo = 1'b1;
    do_op(3'h7, 19'h00010, 16'h0, d);
    check({15'h0, tmo_seen}, 16'h0001);
    do_op(3'h0, 19'h00020, 16'h0, d);
    check(d, arr(19'h00020));
    tmo = 1'b0;
  endtask : t_tmo
  task automatic t_byte; // Byte mode shows only the low lines.
    logic [15:0] d;
    byte_mode = 1'b1;
    do_op(3'h4, 19'h00001, 16'h0, d);
    check(d, {8'h00, PART[7:0]});
    check({15'h0, byte_n}, 16'h0000);
    do_op(3'h2, 19'h7ffff, 16'h0, d);
    check({15'h0, id_mode}, 16'h0000);
    do_op(3'h0, 19'h00077, 16'h0, d);
    check(d, arr(19'h00077) & 16'h00ff);
    byte_mode = 1'b0;
  endtask : t_byte
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    t_array;
    t_id;
    t_tmo;
    t_byte;
    stop_test;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    stop_test;
  end
endmodule : tb_top
`default_nettype wire
